/* File: rtl/bpsc_pkg.sv */
// Purpose: shared constants and types of the board power state controller
// Assumes: 125 MHz standby clock
// Notes:   register offsets are byte addresses of 32-bit words
package bpsc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned SHORT_PRESS_MS  = 4000;
  localparam int unsigned LONG_PRESS_MS   = 6000;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned SHORT_PRESS_CYC = SHORT_PRESS_MS * CYC_PER_MS;
  localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;

  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK   = 8'h0c;
  localparam logic [7:0] OFS_CMD        = 8'h10;

  // control fields
  localparam int         CTRL_TGT_LSB     = 0;
  localparam int         CTRL_DEEP_BIT    = 2;
  localparam int         CTRL_RESTORE_LSB = 3;
  localparam int         CTRL_DUAL_BIT    = 5;
  localparam logic [5:0] CTRL_RESET       = 6'h20;
  localparam int         CMD_SLEEP_BIT    = 0;
  localparam int         CMD_OFF_BIT      = 1;

  localparam logic [1:0] TGT_S3       = 2'h0;
  localparam logic [1:0] TGT_S4       = 2'h1;
  localparam logic [1:0] RESTORE_OFF  = 2'h0;
  localparam logic [1:0] RESTORE_ON   = 2'h1;
  localparam logic [1:0] RESTORE_LAST = 2'h2;

  // ==========================================================
  // pins and events
  localparam int PIN_RTC  = 0;
  localparam int PIN_LAN  = 1;
  localparam int PIN_USB  = 2;
  localparam int PIN_PCIE = 3;
  localparam int PIN_IR   = 4;
  localparam int PIN_AC   = 5;
  localparam int NUM_PINS = 6;
  localparam int NUM_EV   = 7;
  localparam int EV_OFF   = 6;

  localparam logic [4:0] WAKE_ALL    = 5'h1f;
  localparam logic [4:0] WAKE_NO_USB = 5'h1b;
  localparam logic [4:0] WAKE_DEEP   = 5'h01;

  typedef enum logic [1:0] {
    ST_S0 = 2'b00,
    ST_S3 = 2'b01,
    ST_S4 = 2'b10,
    ST_S5 = 2'b11
  } bpsc_state_e;

endpackage

/* File: rtl/bpsc_press_timer.sv */
// Purpose: debounce the power switch and classify each press by its length
// Assumes: switch pin is active low and asynchronous
// Notes:   short pulse on release before the short limit, long pulse while held
module bpsc_press_timer #(
  parameter int unsigned DEBOUNCE_CYC = bpsc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_CYC    = bpsc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned LONG_CYC     = bpsc_pkg::LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // switch pin
  input  wire logic sw_n,
  // classified presses
  output logic      short_p,
  output logic      long_p
);

  logic        meta_reg;
  logic        sync_reg;
  logic        deb_reg;
  logic [31:0] deb_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic        short_reg;
  logic        long_reg;

  // ==========================================================
  // synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= ~sw_n;
      sync_reg <= meta_reg;
    end
  end

  // ==========================================================
  // debounce: level must hold for the whole window to count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      deb_reg     <= 1'b0;
      deb_cnt_reg <= 32'h0;
    end else if (sync_reg == deb_reg) begin
      deb_cnt_reg <= 32'h0;
    end else if (deb_cnt_reg >= DEBOUNCE_CYC - 1) begin
      deb_reg     <= sync_reg;
      deb_cnt_reg <= 32'h0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 32'h1;
    end
  end

  // ==========================================================
  // press length; the counter saturates so a held switch never wraps
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hold_cnt_reg <= 32'h0;
      short_reg    <= 1'b0;
      long_reg     <= 1'b0;
    end else begin
      short_reg <= !deb_reg && (hold_cnt_reg != 32'h0) && (hold_cnt_reg < SHORT_CYC);
      long_reg  <= deb_reg && (hold_cnt_reg == LONG_CYC - 1);
      if (!deb_reg) begin
        hold_cnt_reg <= 32'h0;
      end else if (hold_cnt_reg < LONG_CYC) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end
    end
  end

  assign short_p = short_reg;
  assign long_p  = long_reg;

endmodule // bpsc_press_timer

/* File: rtl/bpsc_top.sv */
// Purpose: board power state controller (working, S3, S4, soft-off)
// Assumes: standby clock and reset stay up while AC is present
// Notes:   switch, AC sense and wake pins are asynchronous and pass two flip-flops first

// Functional notes
// - In soft-off a press shorter than four seconds powers the system on.
// - In working state a short press enters the sleep state chosen in the control register.
// - In working state a press held past six seconds forces soft-off.
// - In S3 or S4 a short press wakes the system to working state.
// - In S3 or S4 a press held past six seconds goes straight to soft-off.
// - Power switch, RTC, LAN, PCIe wake and infrared wake the system from S3, S4 and S5.
// - USB activity wakes only from S3.
// - USB port power is off in S4 and S5.
// - With the deep option set only RTC and the power switch wake from S4 and S5.
// - When AC returns the system goes off, on or to its last state as configured.
// - Any valid wake in S3 returns to working state and turns the supply on.
// - In S3 the supply is off and the LED is amber (dual colour) or dark.
// - A LAN wake-pattern request powers the system up from S3, or from S4 and S5 with the deep option clear.
module bpsc_top #(
  parameter int unsigned DEBOUNCE_CYC = bpsc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_CYC    = bpsc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned LONG_CYC     = bpsc_pkg::LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ,
  // switch, AC sense and wake pins
  input  wire logic        PWR_SW_N,
  input  wire logic        AC_PRESENT,
  input  wire logic        RTC_ALARM,
  input  wire logic        LAN_WAKE,
  input  wire logic        USB_ACTIVITY,
  input  wire logic        PCIE_WAKE_N,
  input  wire logic        INFRARED_REMOTE_WAKE,
  // supply, ports and indicators
  output logic             PSU_ON,
  output logic             USB_PWR_EN,
  output logic             LED_GREEN,
  output logic             LED_AMBER,
  output logic             COLD_BOOT,
  output logic             RESUME_DISK
);

  bpsc_pkg::bpsc_state_e state_reg;
  bpsc_pkg::bpsc_state_e state_next;
  bpsc_pkg::bpsc_state_e sleep_state;

  logic [bpsc_pkg::NUM_PINS-1:0] pin_raw;
  logic [bpsc_pkg::NUM_PINS-1:0] pin_sync;
  logic [bpsc_pkg::NUM_PINS-1:0] pin_prev_reg;
  logic [bpsc_pkg::NUM_PINS-1:0] pin_rise;
  logic [4:0]                    allow;
  logic [4:0]                    wake_hit;
  logic [5:0]                    ctrl_reg;
  logic [bpsc_pkg::NUM_EV-1:0]   int_status_reg;
  logic [bpsc_pkg::NUM_EV-1:0]   int_status_next;
  logic [bpsc_pkg::NUM_EV-1:0]   int_mask_reg;
  logic [bpsc_pkg::NUM_EV-1:0]   ev;
  logic [bpsc_pkg::NUM_EV-1:0]   clr;
  logic [31:0]                   rdata_reg;
  logic [1:0]                    tgt;
  logic [1:0]                    policy;
  logic                          deep_sleep_low_power_option;
  logic                          led_dual;
  logic                          short_p;
  logic                          long_p;
  logic                          ac_ok;
  logic                          ac_rise;
  logic                          ac_steady;
  logic                          pwr_wake;
  logic                          wake_any;
  logic                          cmd_sleep_reg;
  logic                          cmd_off_reg;
  logic                          last_on_reg;
  logic                          cold_boot_reg;
  logic                          resume_disk_reg;
  logic                          psu_on_reg;
  logic                          usb_pwr_reg;
  logic                          led_green_reg;
  logic                          led_amber_reg;
  logic                          irq_reg;

  // ==========================================================
  // power switch timing
  bpsc_press_timer #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC),
    .SHORT_CYC    (SHORT_CYC),
    .LONG_CYC     (LONG_CYC)
  ) u_press (
    .clk     (CLK),
    .rstn    (RSTN),
    .sw_n    (PWR_SW_N),
    .short_p (short_p),
    .long_p  (long_p)
  );

  // ==========================================================
  // pin synchronisers and edge detect
  assign pin_raw = {AC_PRESENT, INFRARED_REMOTE_WAKE, ~PCIE_WAKE_N, USB_ACTIVITY, LAN_WAKE, RTC_ALARM};

  genvar gi;
  generate
    for (gi = 0; gi < bpsc_pkg::NUM_PINS; gi++) begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= pin_raw[gi];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[gi] = sync_reg;
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  // wake sources are edge events so a stuck line cannot hold the system on
  assign pin_rise  = pin_sync & ~pin_prev_reg;
  assign ac_ok     = pin_sync[bpsc_pkg::PIN_AC];
  assign ac_rise   = pin_rise[bpsc_pkg::PIN_AC];
  assign ac_steady = ac_ok & pin_prev_reg[bpsc_pkg::PIN_AC];

  assign tgt                         = ctrl_reg[bpsc_pkg::CTRL_TGT_LSB +: 2];
  assign deep_sleep_low_power_option = ctrl_reg[bpsc_pkg::CTRL_DEEP_BIT];
  assign policy                      = ctrl_reg[bpsc_pkg::CTRL_RESTORE_LSB +: 2];
  assign led_dual                    = ctrl_reg[bpsc_pkg::CTRL_DUAL_BIT];

  // ==========================================================
  // wake qualification
  always_comb begin
    allow = '0;
    unique case (state_reg)
      bpsc_pkg::ST_S0: allow = '0;
      bpsc_pkg::ST_S3: allow = bpsc_pkg::WAKE_ALL;
      bpsc_pkg::ST_S4, bpsc_pkg::ST_S5: begin
        if (deep_sleep_low_power_option) begin
          allow = bpsc_pkg::WAKE_DEEP;
        end else begin
          allow = bpsc_pkg::WAKE_NO_USB;
        end
      end
    endcase
  end

  assign wake_hit = pin_rise[4:0] & allow;
  assign pwr_wake = short_p & (state_reg != bpsc_pkg::ST_S0);
  assign wake_any = (|wake_hit) | pwr_wake;

  always_comb begin
    sleep_state = bpsc_pkg::ST_S5;
    unique case (tgt)
      bpsc_pkg::TGT_S3: sleep_state = bpsc_pkg::ST_S3;
      bpsc_pkg::TGT_S4: sleep_state = bpsc_pkg::ST_S4;
      default:          sleep_state = bpsc_pkg::ST_S5;
    endcase
  end

  // ==========================================================
  // state machine; AC loss overrides everything
  always_comb begin
    state_next = state_reg;
    if (!ac_ok) begin
      state_next = bpsc_pkg::ST_S5;
    end else if (ac_rise) begin
      unique case (policy)
        bpsc_pkg::RESTORE_OFF: state_next = bpsc_pkg::ST_S5;
        bpsc_pkg::RESTORE_ON:  state_next = bpsc_pkg::ST_S0;
        default: state_next = last_on_reg ? bpsc_pkg::ST_S0 : bpsc_pkg::ST_S5;
      endcase
    end else begin
      unique case (state_reg)
        bpsc_pkg::ST_S0: begin
          if (long_p || cmd_off_reg) begin
            state_next = bpsc_pkg::ST_S5;
          end else if (short_p || cmd_sleep_reg) begin
            state_next = sleep_state;
          end
        end
        bpsc_pkg::ST_S3, bpsc_pkg::ST_S4: begin
          if (long_p) begin
            state_next = bpsc_pkg::ST_S5;
          end else if (wake_any) begin
            state_next = bpsc_pkg::ST_S0;
          end
        end
        bpsc_pkg::ST_S5: begin
          if (wake_any) begin
            state_next = bpsc_pkg::ST_S0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_reg <= bpsc_pkg::ST_S5;
    end else begin
      state_reg <= state_next;
    end
  end

  // last on/off state; frozen while AC is gone so the restore sees it
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      last_on_reg <= 1'b0;
    end else if (ac_ok && (state_next != state_reg)) begin
      last_on_reg <= (state_next != bpsc_pkg::ST_S5);
    end
  end

  // how software must come back: from RAM, from disk or cold
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cold_boot_reg   <= 1'b0;
      resume_disk_reg <= 1'b0;
    end else if ((state_next == bpsc_pkg::ST_S0) && (state_reg != bpsc_pkg::ST_S0)) begin
      cold_boot_reg   <= (state_reg == bpsc_pkg::ST_S5);
      resume_disk_reg <= (state_reg == bpsc_pkg::ST_S4);
    end
  end

  // ==========================================================
  // supply, USB power and indicator
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      psu_on_reg    <= 1'b0;
      usb_pwr_reg   <= 1'b0;
      led_green_reg <= 1'b0;
      led_amber_reg <= 1'b0;
    end else begin
      psu_on_reg    <= (state_next == bpsc_pkg::ST_S0);
      usb_pwr_reg   <= (state_next == bpsc_pkg::ST_S0) || (state_next == bpsc_pkg::ST_S3);
      led_green_reg <= (state_next == bpsc_pkg::ST_S0);
      led_amber_reg <= (state_next == bpsc_pkg::ST_S3) && led_dual;
    end
  end

  // ==========================================================
  // register port
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_reg     <= bpsc_pkg::CTRL_RESET;
      int_mask_reg <= '0;
    end else if (WR) begin
      if (ADDR == bpsc_pkg::OFS_CTRL) begin
        ctrl_reg <= WDATA[5:0];
      end
      if (ADDR == bpsc_pkg::OFS_INT_MASK) begin
        int_mask_reg <= WDATA[bpsc_pkg::NUM_EV-1:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cmd_sleep_reg <= 1'b0;
      cmd_off_reg   <= 1'b0;
    end else begin
      cmd_sleep_reg <= WR && (ADDR == bpsc_pkg::OFS_CMD) && WDATA[bpsc_pkg::CMD_SLEEP_BIT];
      cmd_off_reg   <= WR && (ADDR == bpsc_pkg::OFS_CMD) && WDATA[bpsc_pkg::CMD_OFF_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0;
    end else if (!RD) begin
      rdata_reg <= 32'h0;
    end else begin
      unique case (ADDR)
        bpsc_pkg::OFS_CTRL:       rdata_reg <= 32'(ctrl_reg);
        bpsc_pkg::OFS_STATUS:     rdata_reg <= 32'({ac_ok, last_on_reg, state_reg});
        bpsc_pkg::OFS_INT_STATUS: rdata_reg <= 32'(int_status_reg);
        bpsc_pkg::OFS_INT_MASK:   rdata_reg <= 32'(int_mask_reg);
        default:                  rdata_reg <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // interrupts; a new event beats a clear in the same cycle
  assign ev  = {long_p & ac_steady & (state_reg != bpsc_pkg::ST_S5), wake_hit & {5{ac_steady}}, pwr_wake & ac_steady};
  assign clr = (WR && (ADDR == bpsc_pkg::OFS_INT_STATUS)) ? WDATA[bpsc_pkg::NUM_EV-1:0] : '0;
  assign int_status_next = (int_status_reg & ~clr) | ev;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      int_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      int_status_reg <= int_status_next;
      irq_reg        <= |(int_status_next & int_mask_reg);
    end
  end

  assign RDATA       = rdata_reg;
  assign IRQ         = irq_reg;
  assign PSU_ON      = psu_on_reg;
  assign USB_PWR_EN  = usb_pwr_reg;
  assign LED_GREEN   = led_green_reg;
  assign LED_AMBER   = led_amber_reg;
  assign COLD_BOOT   = cold_boot_reg;
  assign RESUME_DISK = resume_disk_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence seq_powered_on;
    state_reg == bpsc_pkg::ST_S0 ##1 PSU_ON && LED_GREEN;
  endsequence

  sequence seq_powered_off;
    state_reg == bpsc_pkg::ST_S5 ##1 !PSU_ON && !USB_PWR_EN && !LED_GREEN;
  endsequence

  chk_off_short_on: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S5 && short_p |=> seq_powered_on)
    else $error("short press in soft-off did not power on");
  chk_on_short_sleep: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S0 && short_p |=> state_reg == $past(sleep_state))
    else $error("short press in working state missed the sleep target");
  chk_on_long_off: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S0 && long_p |=> seq_powered_off)
    else $error("long press in working state did not force off");
  chk_sleep_short_wake: assert property (
    ac_steady && (state_reg == bpsc_pkg::ST_S3 || state_reg == bpsc_pkg::ST_S4) && short_p |=> seq_powered_on)
    else $error("short press in sleep did not wake");
  chk_sleep_long_off: assert property (
    ac_steady && (state_reg == bpsc_pkg::ST_S3 || state_reg == bpsc_pkg::ST_S4) && long_p |=> seq_powered_off)
    else $error("long press in sleep did not go to soft-off");
  chk_s5_cold_flag: assert property (
    state_reg == bpsc_pkg::ST_S5 && state_next == bpsc_pkg::ST_S0 |=> COLD_BOOT && !RESUME_DISK)
    else $error("leaving soft-off not flagged as cold boot");
  chk_pcie_wake_s5: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S5 && !deep_sleep_low_power_option && pin_rise[bpsc_pkg::PIN_PCIE]
    |=> seq_powered_on)
    else $error("pcie wake ignored in soft-off");
  chk_usb_only_s3: assert property (
    ac_steady && (state_reg == bpsc_pkg::ST_S4 || state_reg == bpsc_pkg::ST_S5) && !short_p && !long_p
    && ((pin_rise[4:0] & bpsc_pkg::WAKE_NO_USB) == 5'h00) |=> $stable(state_reg))
    else $error("usb activity woke from S4 or S5");
  chk_usb_power_off: assert property (
    state_reg == bpsc_pkg::ST_S4 || state_reg == bpsc_pkg::ST_S5 |-> !USB_PWR_EN)
    else $error("usb power on in S4 or S5");
  chk_deep_lan_ignored: assert property (
    ac_steady && deep_sleep_low_power_option && state_reg == bpsc_pkg::ST_S4 && pin_rise[bpsc_pkg::PIN_LAN]
    && !pin_rise[bpsc_pkg::PIN_RTC] && !short_p && !long_p |=> state_reg == bpsc_pkg::ST_S4)
    else $error("lan wake honoured with deep option set");
  chk_restore_last: assert property (
    ac_rise && policy == bpsc_pkg::RESTORE_LAST && last_on_reg |=> seq_powered_on)
    else $error("last on state not restored after AC return");
  chk_last_state_hold: assert property (
    !ac_ok |=> $stable(last_on_reg))
    else $error("last power state changed while AC lost");
  chk_s3_resume: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S3 && (|wake_hit) && !long_p
    |=> (!COLD_BOOT && !RESUME_DISK) ##0 seq_powered_on)
    else $error("valid wake in S3 did not resume");
  chk_s3_indicator: assert property (
    state_reg == bpsc_pkg::ST_S3 && $stable(ctrl_reg) |-> !PSU_ON && LED_AMBER == led_dual && !LED_GREEN)
    else $error("supply or LED wrong in S3");
  chk_lan_wake_s3: assert property (
    ac_steady && state_reg == bpsc_pkg::ST_S3 && pin_rise[bpsc_pkg::PIN_LAN] && !long_p |=> seq_powered_on)
    else $error("lan wake request ignored in S3");

endmodule // bpsc_top

/* File: verif/bpsc_far_model.sv */
// Purpose: power switch, wake sources and AC sense facing the controller
// Assumes: requests change just after a rising edge
// Notes:   idle levels: switch released high, wake lines low, PCIe wake high
module bpsc_far_model (
  // clock
  input  wire logic clk,
  // pins toward the controller
  output logic      pwr_sw_n,
  output logic      ac_present,
  output logic      rtc,
  output logic      lan,
  output logic      usb,
  output logic      pcie_n,
  output logic      ir
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wk;
  initial begin
    pwr_sw_n   = 1'b1;
    ac_present = 1'b1;
    wk         = 5'h00;
  end
  assign rtc    = wk[bpsc_pkg::PIN_RTC];
  assign lan    = wk[bpsc_pkg::PIN_LAN];
  assign usb    = wk[bpsc_pkg::PIN_USB];
  assign pcie_n = ~wk[bpsc_pkg::PIN_PCIE];
  assign ir     = wk[bpsc_pkg::PIN_IR];
  // ==========================================================
  // switch press held n cycles; no bounce, so debounce only delays
  task automatic press(input int n);
    @(posedge clk) pwr_sw_n <= 1'b0;
    repeat (n) @(posedge clk);
    pwr_sw_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  // wake pulse on one source, long enough to pass the synchroniser
  task automatic pulse(input int i);
    @(posedge clk) wk <= wk | (5'h01 << i);
    repeat (4) @(posedge clk);
    wk <= wk & ~(5'h01 << i);
  endtask
  // AC sense level, changed just after an edge
  task automatic set_ac(input logic v);
    @(posedge clk) ac_present <= v;
  endtask
endmodule // bpsc_far_model

/* File: verif/tb_top.sv */
// Purpose: self-checking bench of the power state controller
// Assumes: shortened press and debounce counts
// Notes:   waits on supply enable are bounded
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, wr, rd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic        irq, sw_n, ac, rtc, lan, usb, pcie_n, ir;
  logic        psu, usb_en, green, amber, cold, disk;
  int          error_cnt = 0;
  int          n_tests   = 0;
  // ==========================================================
  // clock, partner and design
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  bpsc_far_model far (.clk(clk), .pwr_sw_n(sw_n), .ac_present(ac), .rtc(rtc), .lan(lan),
    .usb(usb), .pcie_n(pcie_n), .ir(ir));
  bpsc_top #(.DEBOUNCE_CYC(4), .SHORT_CYC(40), .LONG_CYC(60)) dut (.CLK(clk), .RSTN(rstn),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .PWR_SW_N(sw_n),
    .AC_PRESENT(ac), .RTC_ALARM(rtc), .LAN_WAKE(lan), .USB_ACTIVITY(usb), .PCIE_WAKE_N(pcie_n),
    .INFRARED_REMOTE_WAKE(ir), .PSU_ON(psu), .USB_PWR_EN(usb_en), .LED_GREEN(green),
    .LED_AMBER(amber), .COLD_BOOT(cold), .RESUME_DISK(disk));
  // ==========================================================
  // register bus and helpers
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic wait_psu(input logic v);
    for (int i = 0; i < 300 && psu !== v; i++) @(posedge clk);
    #1 `CHK(psu, v)
  endtask
  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    `CHK(psu, 1'b0)
    rreg(bpsc_pkg::OFS_CTRL);
    `CHK(r, 32'h0000_0020)
    rreg(bpsc_pkg::OFS_STATUS);
    `CHK(r[1:0], 2'h3)
  endtask
  task automatic t_s3;
    far.press(20);
    wait_psu(1'b1);
    `CHK({cold, green}, 2'h3)
    wreg(bpsc_pkg::OFS_INT_MASK, 32'h0000_007f);
    far.press(20);
    wait_psu(1'b0);
    `CHK({amber, usb_en, green}, 3'h6)
    far.pulse(bpsc_pkg::PIN_USB);
    wait_psu(1'b1);
    `CHK({cold, irq}, 2'h1)
    rreg(bpsc_pkg::OFS_INT_STATUS);
    `CHK(r[3], 1'b1)
    wreg(bpsc_pkg::OFS_INT_STATUS, 32'h0000_007f);
    #1 `CHK(irq, 1'b0)
    wreg(bpsc_pkg::OFS_CMD, 32'h0000_0001);
    wait_psu(1'b0);
    far.press(20);
    wait_psu(1'b1);
  endtask
  task automatic t_s4;
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0021);
    wreg(bpsc_pkg::OFS_CMD, 32'h0000_0001);
    wait_psu(1'b0);
    `CHK(usb_en, 1'b0)
    far.pulse(bpsc_pkg::PIN_USB);
    repeat (10) @(posedge clk);
    `CHK(psu, 1'b0)
    far.pulse(bpsc_pkg::PIN_LAN);
    wait_psu(1'b1);
    `CHK(disk, 1'b1)
  endtask
  task automatic t_long;
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0020);
    far.press(50);
    `CHK(psu, 1'b1)
    far.press(80);
    wait_psu(1'b0);
    rreg(bpsc_pkg::OFS_INT_STATUS);
    `CHK(r[6], 1'b1)
    far.pulse(bpsc_pkg::PIN_IR);
    wait_psu(1'b1);
    wreg(bpsc_pkg::OFS_CMD, 32'h0000_0001);
    wait_psu(1'b0);
    far.press(80);
    rreg(bpsc_pkg::OFS_STATUS);
    `CHK(r[1:0], 2'h3)
  endtask
  task automatic t_deep;
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0024);
    far.pulse(bpsc_pkg::PIN_PCIE);
    repeat (10) @(posedge clk);
    `CHK(psu, 1'b0)
    far.pulse(bpsc_pkg::PIN_RTC);
    wait_psu(1'b1);
  endtask
  task automatic t_ac;
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0030);
    far.set_ac(1'b0);
    wait_psu(1'b0);
    repeat (10) @(posedge clk);
    far.set_ac(1'b1);
    wait_psu(1'b1);
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0022);
    far.press(20);
    wait_psu(1'b0);
    rreg(bpsc_pkg::OFS_STATUS);
    `CHK(r[3:0], 4'hb)
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0028);
    far.set_ac(1'b0);
    repeat (10) @(posedge clk);
    far.set_ac(1'b1);
    wait_psu(1'b1);
    wreg(bpsc_pkg::OFS_CMD, 32'h0000_0002);
    wait_psu(1'b0);
    far.press(20);
    wait_psu(1'b1);
    wreg(bpsc_pkg::OFS_CTRL, 32'h0000_0020);
    far.set_ac(1'b0);
    repeat (10) @(posedge clk);
    far.set_ac(1'b1);
    repeat (10) @(posedge clk);
    `CHK(psu, 1'b0)
    rreg(bpsc_pkg::OFS_STATUS);
    `CHK(r[3:0], 4'hf)
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    t_reset();
    t_s3();
    t_s4();
    t_long();
    t_deep();
    t_ac();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule // tb_top
